/* File: match_channel.sv */
// One compare channel: working value, buffer, buffer-valid bit and match
`timescale 1ns/1ps
module match_channel
  import timer16_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Counter to compare against
  input wire logic [W-1:0] counter_value,
  // Committed 16-bit writes
  input wire logic cmp_wr,
  input wire logic buf_wr,
  input wire logic [W-1:0] wr_data,
  // Update condition with transfers allowed
  input wire logic transfer,
  // State out
  output logic [W-1:0] match_value,
  output logic [W-1:0] match_value_buffer,
  output logic match_buffer_valid,
  output logic match_hit
);

  // ----------------------------------------------------------------
  // Working compare register
  // ----------------------------------------------------------------
  // Software write first, else copy from buffer on transfer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      match_value <= RST_MATCH;
    end else if (cmp_wr) begin
      match_value <= wr_data;
    end else if (transfer) begin
      match_value <= match_value_buffer;
    end
  end

  // Buffer register, written only by software
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      match_value_buffer <= RST_MATCH;
    end else if (buf_wr) begin
      match_value_buffer <= wr_data;
    end
  end

  // Valid bit: a write sets it, a transfer clears it, set wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      match_buffer_valid <= 1'b0;
    end else if (buf_wr) begin
      match_buffer_valid <= 1'b1;
    end else if (transfer) begin
      match_buffer_valid <= 1'b0;
    end
  end

  // Continuous equality against the counter
  assign match_hit = (counter_value == match_value);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_buf_copy;
    @(posedge sys_clk) disable iff (rst)
      (transfer && !cmp_wr) |=> (match_value == $past(match_value_buffer));
  endproperty
  a_buf_copy: assert property (p_buf_copy) else $error("buffer not copied");

  property p_valid_life;
    @(posedge sys_clk) disable iff (rst)
      buf_wr |=> match_buffer_valid ##1 (match_buffer_valid || $past(transfer));
  endproperty
  a_valid_life: assert property (p_valid_life) else $error("valid bit wrong");

endmodule // match_channel

/* File: timer16_normal_mode_regs.sv */
// Register file, counter and flags of a 16-bit timer in normal mode
`timescale 1ns/1ps
module timer16_normal_mode_regs
  import timer16_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register access port
  input wire reg_req_t req,
  output logic [7:0] rdata,
  // Counting engine controls
  input wire engine_in_t engine,
  input wire logic cpu_halted,
  // Timer state out
  output logic [W-1:0] counter_value,
  output logic [NUM_CH-1:0] match_hit,
  output logic top_buffer_valid,
  output logic [NUM_CH-1:0] match_buffer_valid,
  output logic irq
);
  // Every check below samples on the system clock and rests in reset
  default clocking check_clk @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  // Hit on a 16-bit pair: bit 1 high byte, bit 0 low byte
  function automatic logic [1:0] word_hit(input logic [7:0] a, input logic [7:0] base);
    word_hit = {a == (base + HIGH_BYTE_OFS), a == base};
  endfunction
  // Base offset of channel n in a strided array
  function automatic logic [7:0] chan_ofs(input logic [7:0] base, input int n);
    chan_ofs = base + 8'(n) * WORD_STRIDE;
  endfunction
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] irq_enables_q; // Interrupt enables
  logic [7:0] irq_flags_q; // Sticky flags
  logic [7:0] debug_behaviour_q; // Run-while-halted control
  logic [7:0] byte_stage_q; // Shared staging byte
  logic [W-1:0] top_value_q; // Period
  logic [W-1:0] top_value_buffer_q; // Period buffer
  logic top_buffer_valid_q; // Period buffer valid
  logic [W-1:0] match_value [NUM_CH]; // Working compare values
  logic [W-1:0] match_value_buffer [NUM_CH]; // Compare buffers
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [1:0] hit_cnt; // Counter pair
  logic [1:0] hit_top; // Top pair
  logic [1:0] hit_top_buf; // Top buffer pair
  logic [1:0] hit_cmp [NUM_CH]; // Match pairs
  logic [1:0] hit_buf [NUM_CH]; // Match buffer pairs
  // Per-pair hit vectors
  always_comb begin
    hit_cnt = word_hit(req.addr, OFS_COUNTER);
    hit_top = word_hit(req.addr, OFS_TOP);
    hit_top_buf = word_hit(req.addr, OFS_TOP_BUF);
    for (int n = 0; n < NUM_CH; n++) begin
      hit_cmp[n] = word_hit(req.addr, chan_ofs(OFS_MATCH_BASE, n));
      hit_buf[n] = word_hit(req.addr, chan_ofs(OFS_MATCH_BUF_BASE, n));
    end
  end
  logic is_byte; // Address names an 8-bit register
  logic [7:0] byte_val; // Its value
  logic is_word; // Address names one half of a pair
  logic is_high; // The high half
  logic [W-1:0] word_val; // Whole value of the pair
  // Read mux for every mapped address
  always_comb begin
    is_byte = 1'b0;
    byte_val = RST_BYTE;
    is_word = 1'b0;
    is_high = 1'b0;
    word_val = '0;
    if (req.addr == OFS_IRQ_ENABLES) begin
      is_byte = 1'b1;
      byte_val = irq_enables_q;
    end else if (req.addr == OFS_IRQ_FLAGS) begin
      is_byte = 1'b1;
      byte_val = irq_flags_q;
    end else if (req.addr == OFS_DEBUG) begin
      is_byte = 1'b1;
      byte_val = debug_behaviour_q;
    end else if (req.addr == OFS_STAGE) begin
      is_byte = 1'b1;
      byte_val = byte_stage_q;
    end else if (|hit_cnt) begin
      is_word = 1'b1;
      is_high = hit_cnt[1];
      word_val = counter_value;
    end else if (|hit_top) begin
      is_word = 1'b1;
      is_high = hit_top[1];
      word_val = top_value_q;
    end else if (|hit_top_buf) begin
      is_word = 1'b1;
      is_high = hit_top_buf[1];
      word_val = top_value_buffer_q;
    end else begin
      // Channel pairs, unmapped addresses fall through as zero
      for (int n = 0; n < NUM_CH; n++) begin
        if (|hit_cmp[n]) begin
          is_word = 1'b1;
          is_high = hit_cmp[n][1];
          word_val = match_value[n];
        end
        if (|hit_buf[n]) begin
          is_word = 1'b1;
          is_high = hit_buf[n][1];
          word_val = match_value_buffer[n];
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  logic [W-1:0] commit_data; // High byte joined with staged low byte
  logic wr_cnt; // Counter commit
  logic wr_top; // Top commit
  logic wr_top_buf; // Top buffer commit
  logic [NUM_CH-1:0] wr_cmp; // Match commits
  logic [NUM_CH-1:0] wr_buf; // Match buffer commits
  logic [7:0] clr_bits; // Write-one-to-clear mask
  assign commit_data = {req.wdata, byte_stage_q};
  assign wr_cnt = req.wr && hit_cnt[1];
  assign wr_top = req.wr && hit_top[1];
  assign wr_top_buf = req.wr && hit_top_buf[1];
  assign clr_bits = (req.wr && req.addr == OFS_IRQ_FLAGS) ? (req.wdata & IRQ_MASK) : 8'h00;
  // Commit strobes per channel
  always_comb begin
    for (int n = 0; n < NUM_CH; n++) begin
      wr_cmp[n] = req.wr && hit_cmp[n][1];
      wr_buf[n] = req.wr && hit_buf[n][1];
    end
  end
  // ----------------------------------------------------------------
  // Counting and update condition
  // ----------------------------------------------------------------
  logic run_ok; // Counter may advance and take events
  logic step; // Tick that is honoured
  logic top_hit; // Counting up, at TOP
  logic bottom_hit; // Counting down, at BOTTOM
  logic wrap_event; // Chosen wrap condition
  logic update_cond; // Buffer update condition
  logic transfer; // Update with transfers allowed
  assign run_ok = !cpu_halted || debug_behaviour_q[BIT_RUN_HALTED];
  assign step = run_ok && engine.tick;
  assign top_hit = step && !engine.down && (counter_value == top_value_q);
  assign bottom_hit = step && engine.down && (counter_value == RST_COUNTER);
  assign wrap_event = engine.wrap_at_bottom ? bottom_hit : top_hit;
  assign update_cond = top_hit || bottom_hit || engine.force_update;
  assign transfer = update_cond && !engine.hold_buffer_transfer;
  // Counter: software write first, then one step per tick
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      counter_value <= RST_COUNTER;
    end else if (wr_cnt) begin
      counter_value <= commit_data;
    end else if (top_hit) begin
      counter_value <= RST_COUNTER;
    end else if (bottom_hit) begin
      counter_value <= top_value_q;
    end else if (step) begin
      counter_value <= engine.down ? counter_value - 1'b1 : counter_value + 1'b1;
    end
  end
  property p_halt_freeze;
    (cpu_halted && !debug_behaviour_q[BIT_RUN_HALTED] && !wr_cnt) |=> $stable(counter_value);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved halted");
  property p_cpu_wins;
    wr_cnt |=> (counter_value == $past(commit_data));
  endproperty
  a_cpu_wins: assert property (p_cpu_wins) else $error("counter write lost");
  // ----------------------------------------------------------------
  // Period and its buffer
  // ----------------------------------------------------------------
  // Top value: software write, else load from buffer on transfer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      top_value_q <= RST_TOP;
    end else if (wr_top) begin
      top_value_q <= commit_data;
    end else if (transfer) begin
      top_value_q <= top_value_buffer_q;
    end
  end
  property p_hold;
    (engine.hold_buffer_transfer && !wr_top) |=> $stable(top_value_q);
  endproperty
  a_hold: assert property (p_hold) else $error("transfer while held");
  // Top buffer holds software writes only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      top_value_buffer_q <= RST_TOP;
    end else if (wr_top_buf) begin
      top_value_buffer_q <= commit_data;
    end
  end
  // Top buffer valid: set by a write, cleared by a transfer, set wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      top_buffer_valid_q <= 1'b0;
    end else if (wr_top_buf) begin
      top_buffer_valid_q <= 1'b1;
    end else if (transfer) begin
      top_buffer_valid_q <= 1'b0;
    end
  end
  assign top_buffer_valid = top_buffer_valid_q;
  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    match_channel #(.W(W)) u_ch (
      .sys_clk(sys_clk),
      .rst(rst),
      .counter_value(counter_value),
      .cmp_wr(wr_cmp[g]),
      .buf_wr(wr_buf[g]),
      .wr_data(commit_data),
      .transfer(transfer),
      .match_value(match_value[g]),
      .match_value_buffer(match_value_buffer[g]),
      .match_buffer_valid(match_buffer_valid[g]),
      .match_hit(match_hit[g])
    );
  end
  // ----------------------------------------------------------------
  // Control and status bytes
  // ----------------------------------------------------------------
  // Interrupt enables, unused bits read zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_enables_q <= RST_BYTE;
    end else if (req.wr && req.addr == OFS_IRQ_ENABLES) begin
      irq_enables_q <= req.wdata & IRQ_MASK;
    end
  end
  logic [7:0] set_bits; // Hardware events this cycle
  // Event vector in flag layout
  assign set_bits = (8'(match_hit) << BIT_MATCH_BASE) | (8'(wrap_event) << BIT_WRAP);
  // Sticky flags, hardware set beats software clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_flags_q <= RST_BYTE;
    end else begin
      irq_flags_q <= (irq_flags_q & ~clr_bits) | set_bits;
    end
  end
  property p_match_flag;
    match_hit[0] |=> irq_flags_q[BIT_MATCH_BASE];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag not set");
  property p_flag_clear;
    (clr_bits[BIT_MATCH_BASE + 1] && !match_hit[1]) |=> !irq_flags_q[BIT_MATCH_BASE + 1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
  property p_wrap_flag;
    (top_hit && !engine.wrap_at_bottom) |=> irq_flags_q[BIT_WRAP];
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap flag not set");
  property p_wrap_sticky;
    (irq_flags_q[BIT_WRAP] && !clr_bits[BIT_WRAP]) |=> irq_flags_q[BIT_WRAP];
  endproperty
  a_wrap_sticky: assert property (p_wrap_sticky) else $error("wrap flag lost");
  // Debug behaviour byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      debug_behaviour_q <= RST_BYTE;
    end else if (req.wr && req.addr == OFS_DEBUG) begin
      debug_behaviour_q <= req.wdata & DEBUG_MASK;
    end
  end
  // Staging byte: direct writes, low-byte writes, low-byte reads
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      byte_stage_q <= RST_BYTE;
    end else if (req.wr && (req.addr == OFS_STAGE || (is_word && !is_high))) begin
      byte_stage_q <= req.wdata;
    end else if (req.rd && is_word && !is_high) begin
      byte_stage_q <= word_val[15:8];
    end
  end
  // Read data, registered; high half returns the staged byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= RST_BYTE;
    end else if (req.rd) begin
      if (is_byte) begin
        rdata <= byte_val;
      end else if (is_word) begin
        rdata <= is_high ? byte_stage_q : word_val[7:0];
      end else begin
        rdata <= RST_BYTE;
      end
    end
  end
  // Interrupt request from enabled flags
  assign irq = |(irq_flags_q & irq_enables_q);
  property p_irq;
    (irq_flags_q[BIT_WRAP] && irq_enables_q[BIT_WRAP]) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
endmodule // timer16_normal_mode_regs

/* File: timer16_normal_mode_regs_bench.sv */
// Self-checking bench for the 16-bit timer register block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module timer16_normal_mode_regs_bench
  import timer16_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk; // 100 MHz clock
  logic rst; // Async reset, active high
  reg_req_t req; // Register access request
  logic [7:0] rdata; // Read data
  engine_in_t eng; // Engine controls
  logic cpu_halted; // Break debug halt
  logic [15:0] counter_value; // Counter out
  logic [NUM_CH-1:0] match_hit; // Compare hits
  logic top_buffer_valid; // Top buffer valid
  logic [NUM_CH-1:0] match_buffer_valid; // Match buffer valids
  logic irq; // Interrupt request
  int error_cnt; // Mismatch count
  int checks_done; // Comparison count
  logic [15:0] v; // Read-back scratch
  // One table row: address, width, write or not, value, expected read
  typedef struct {logic [7:0] a; bit w16; bit wr; logic [15:0] wv; logic [15:0] ex;} row_t;
  row_t rows[21];

  // ----------------------------------------------------------------
  // Design under test
  // ----------------------------------------------------------------
  timer16_normal_mode_regs #(.W(16)) timer16_normal_mode_regs_inst (
    .sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata), .engine(eng),
    .cpu_halted(cpu_halted), .counter_value(counter_value), .match_hit(match_hit),
    .top_buffer_valid(top_buffer_valid), .match_buffer_valid(match_buffer_valid), .irq(irq));

  // Clock generator
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One byte access, held for one sampling edge, read data taken after it
  task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk); #1;
    req.wr = w; req.rd = !w; req.addr = a; req.wdata = d;
    @(posedge sys_clk); #1;
    req.wr = 1'b0; req.rd = 1'b0;
  endtask
  // Low byte first, then high byte
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, a, d[7:0]);
    acc(1'b1, a + HIGH_BYTE_OFS, d[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a);
    acc(1'b0, a, 8'h00); v[7:0] = rdata;
    acc(1'b0, a + HIGH_BYTE_OFS, 8'h00); v[15:8] = rdata;
  endtask
  // Hold the step request for n sampling edges
  task automatic steps(input int n);
    @(posedge sys_clk); #1; eng.tick = 1'b1;
    repeat (n) @(posedge sys_clk);
    #1; eng.tick = 1'b0;
  endtask
  // One-cycle forced update
  task automatic kick();
    @(posedge sys_clk); #1; eng.force_update = 1'b1;
    @(posedge sys_clk); #1; eng.force_update = 1'b0;
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 20 us
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0; checks_done = 0; v = 16'h0000;
    req = '0; eng = '0; cpu_halted = 1'b0; rst = 1'b1;
    // Reset values, then write and read-back of every register but the flags
    rows = '{
      '{8'h20, 1, 0, 16'h0000, 16'h0000}, '{8'h26, 1, 0, 16'h0000, 16'hFFFF},
      '{8'h28, 1, 0, 16'h0000, 16'h0000}, '{8'h2C, 1, 0, 16'h0000, 16'h0000},
      '{8'h36, 1, 0, 16'h0000, 16'hFFFF}, '{8'h3A, 1, 0, 16'h0000, 16'h0000},
      '{8'h0A, 0, 0, 16'h0000, 16'h0000}, '{8'h0B, 0, 0, 16'h0000, 16'h0070},
      '{8'h20, 1, 1, 16'h1234, 16'h1234}, '{8'h26, 1, 1, 16'hA55A, 16'hA55A},
      '{8'h28, 1, 1, 16'h0100, 16'h0100}, '{8'h2A, 1, 1, 16'h0200, 16'h0200},
      '{8'h2C, 1, 1, 16'h0300, 16'h0300}, '{8'h36, 1, 1, 16'h0010, 16'h0010},
      '{8'h38, 1, 1, 16'h0007, 16'h0007}, '{8'h3A, 1, 1, 16'h0008, 16'h0008},
      '{8'h3C, 1, 1, 16'h0009, 16'h0009}, '{8'h0A, 0, 1, 16'h00FF, 16'h0071},
      '{8'h0E, 0, 1, 16'h00FF, 16'h0001}, '{8'h0F, 0, 1, 16'h005A, 16'h005A},
      '{8'h40, 0, 1, 16'h00FF, 16'h0000}};
    repeat (16) @(posedge sys_clk);
    #1; rst = 1'b0;
    // Table loop
    foreach (rows[i]) begin
      if (rows[i].wr && rows[i].w16) wr16(rows[i].a, rows[i].wv);
      else if (rows[i].wr) acc(1'b1, rows[i].a, rows[i].wv[7:0]);
      if (rows[i].w16) rd16(rows[i].a);
      else begin
        acc(1'b0, rows[i].a, 8'h00); v = {8'h00, rdata};
      end
      `CHK(v, rows[i].ex)
    end
    `CHK(top_buffer_valid, 1'b1)
    `CHK(match_buffer_valid, 3'b111)
    // Wrap at TOP loads buffers and clears valids
    acc(1'b1, OFS_DEBUG, 8'h00);
    acc(1'b1, OFS_IRQ_ENABLES, 8'h01);
    acc(1'b1, OFS_IRQ_FLAGS, 8'hFF);
    `CHK(irq, 1'b0)
    wr16(OFS_TOP, 16'h0005);
    wr16(OFS_COUNTER, 16'h0003);
    steps(3);
    `CHK(counter_value, 16'h0000)
    acc(1'b0, OFS_IRQ_FLAGS, 8'h00);
    `CHK(rdata, 8'h01)
    `CHK(irq, 1'b1)
    rd16(OFS_TOP);
    `CHK(v, 16'h0010)
    rd16(8'h2C);
    `CHK(v, 16'h0009)
    `CHK({top_buffer_valid, match_buffer_valid}, 4'h0)
    // Writing zero keeps the flag, writing one clears it
    acc(1'b1, OFS_IRQ_FLAGS, 8'h00);
    acc(1'b0, OFS_IRQ_FLAGS, 8'h00);
    `CHK(rdata, 8'h01)
    acc(1'b1, OFS_IRQ_FLAGS, 8'h01);
    acc(1'b0, OFS_IRQ_FLAGS, 8'h00);
    `CHK(rdata, 8'h00)
    `CHK(irq, 1'b0)
    // Held transfer, then released
    eng.hold_buffer_transfer = 1'b1;
    wr16(OFS_TOP_BUF, 16'h0020);
    kick();
    rd16(OFS_TOP);
    `CHK(v, 16'h0010)
    `CHK(top_buffer_valid, 1'b1)
    eng.hold_buffer_transfer = 1'b0;
    kick();
    rd16(OFS_TOP);
    `CHK(v, 16'h0020)
    `CHK(top_buffer_valid, 1'b0)
    // Debug halt freezes unless the run bit is set
    wr16(OFS_COUNTER, 16'h0000);
    cpu_halted = 1'b1;
    steps(4);
    `CHK(counter_value, 16'h0000)
    acc(1'b1, OFS_DEBUG, 8'h01);
    steps(7);
    `CHK(counter_value, 16'h0007)
    `CHK(match_hit, 3'b001)
    acc(1'b0, OFS_IRQ_FLAGS, 8'h00);
    `CHK(rdata, 8'h10)
    acc(1'b1, OFS_IRQ_FLAGS, 8'h10);
    acc(1'b0, OFS_IRQ_FLAGS, 8'h00);
    `CHK(rdata, 8'h10)
    acc(1'b1, OFS_IRQ_ENABLES, 8'h10);
    `CHK(irq, 1'b1)
    // Counting down, wrap flag at BOTTOM
    eng.down = 1'b1; eng.wrap_at_bottom = 1'b1;
    wr16(OFS_COUNTER, 16'h0001);
    acc(1'b1, OFS_IRQ_FLAGS, 8'hFF);
    steps(2);
    `CHK(counter_value, 16'h0020)
    acc(1'b0, OFS_IRQ_FLAGS, 8'h00);
    `CHK(rdata, 8'h01)
    // Counter write lands on a step edge and wins
    eng.tick = 1'b1;
    wr16(OFS_COUNTER, 16'h00AA);
    eng.tick = 1'b0;
    `CHK(counter_value, 16'h00AA)
    // Mid-run reset
    @(posedge sys_clk); #1; rst = 1'b1;
    #1;
    `CHK({counter_value, irq, top_buffer_valid, rdata}, 26'h0)
    repeat (2) @(posedge sys_clk);
    #1; rst = 1'b0;
    rd16(OFS_TOP);
    `CHK(v, 16'hFFFF)
    tally_and_finish();
  end
endmodule // timer16_normal_mode_regs_bench

/* File: timer16_pkg.sv */
// Shared constants and carrier types for the 16-bit timer register block
package timer16_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 3;

  // ----------------------------------------------------------------
  // Byte offsets of the register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_ENABLES = 8'h0A;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0B;
  localparam logic [7:0] OFS_DEBUG = 8'h0E;
  localparam logic [7:0] OFS_STAGE = 8'h0F;
  localparam logic [7:0] OFS_COUNTER = 8'h20;
  localparam logic [7:0] OFS_TOP = 8'h26;
  localparam logic [7:0] OFS_MATCH_BASE = 8'h28;
  localparam logic [7:0] OFS_TOP_BUF = 8'h36;
  localparam logic [7:0] OFS_MATCH_BUF_BASE = 8'h38;
  localparam logic [7:0] WORD_STRIDE = 8'h02;
  localparam logic [7:0] HIGH_BYTE_OFS = 8'h01;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int BIT_WRAP = 0;
  localparam int BIT_MATCH_BASE = 4;
  localparam int BIT_RUN_HALTED = 0;
  localparam logic [7:0] IRQ_MASK = 8'h71;
  localparam logic [7:0] DEBUG_MASK = 8'h01;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [15:0] RST_TOP = 16'hFFFF;
  localparam logic [15:0] RST_MATCH = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // One register access from the CPU or the debug port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Controls coming from the counting engine and control registers
  typedef struct packed {
    logic tick;
    logic down;
    logic wrap_at_bottom;
    logic force_update;
    logic hold_buffer_transfer;
  } engine_in_t;

endpackage
